// ### rtl/wcw_ctrl.sv
// Watchdog clock source and window select control register with Avalon-MM slave
//
// Summary of operation
// - Bits 6:4 select watchdog clock: 000 low-freq 31 kHz, 001 medium 31.25 kHz.
// - Bits 2:0 select window; 000 opens 12.5 percent, 111 fully open.
// - Bits 7 and 3 read zero and ignore writes.
// - Config clock field 111 resets clock select to 000 each reset.
// - Reset loads window select from the config window field.
// - Config clock field not 111 makes clock select read-only.
// - Config window field not 111 makes window select read-only.
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module wcw_ctrl
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [2:0]  config_clock_source_sel,
   input  wire logic [2:0]  config_window_sel,
   output logic [2:0]       wd_clock_source_sel,
   output logic [2:0]       wd_window_sel
);
   import wcw_pkg::*;

   logic [2:0]  cs_ff;
   logic [2:0]  win_ff;
   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic        wr_ctrl;
   logic        cs_wr_ok;
   logic        win_wr_ok;
   logic [7:0]  ctrl_view;

   // One wait state: request is answered on the second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign wr_ctrl   = avs_write & ~ack_ff & (avs_address == CTRL_REG_OFFSET)
                      & avs_byteenable[0];
   assign cs_wr_ok  = (config_clock_source_sel == CFG_WRITABLE);
   assign win_wr_ok = (config_window_sel == CFG_WRITABLE);
   assign ctrl_view = {1'b0, cs_ff, 1'b0, win_ff};

   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read | avs_write) & ~ack_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cs_ff <= CS_RESET_CODE;
      end else if (wr_ctrl && cs_wr_ok) begin
         cs_ff <= avs_writedata[CS_LSB +: 3];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         win_ff <= config_window_sel;
      end else if (wr_ctrl && win_wr_ok) begin
         win_ff <= avs_writedata[WIN_LSB +: 3];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_ff <= UNMAPPED_READ;
      end else if (avs_read && !ack_ff) begin
         unique case (avs_address)
            CTRL_REG_OFFSET: rdata_ff <= {24'h00_0000, ctrl_view};
            CFG_STAT_OFFSET: rdata_ff <= {24'h00_0000, 1'b0, config_clock_source_sel,
                                          1'b0, config_window_sel};
            default:         rdata_ff <= UNMAPPED_READ;
         endcase
      end
   end

   assign avs_readdata        = rdata_ff;
   assign wd_clock_source_sel = cs_ff;
   assign wd_window_sel       = win_ff;

   property p_cs_locked;
      @(posedge mclk) disable iff (rst)
         !cs_wr_ok |=> $stable(cs_ff);
   endproperty
   a_cs_locked: assert property (p_cs_locked) else $error("locked clock select changed");

   property p_win_locked;
      @(posedge mclk) disable iff (rst)
         !win_wr_ok |=> $stable(win_ff);
   endproperty
   a_win_locked: assert property (p_win_locked) else $error("window changed while locked");

   property p_cs_write;
      @(posedge mclk) disable iff (rst)
         (wr_ctrl && cs_wr_ok) |=> (wd_clock_source_sel == $past(avs_writedata[6:4]));
   endproperty
   a_cs_write: assert property (p_cs_write) else $error("clock select write lost");

   property p_win_write;
      @(posedge mclk) disable iff (rst)
         (wr_ctrl && win_wr_ok) |=> (wd_window_sel == $past(avs_writedata[2:0]));
   endproperty
   a_win_write: assert property (p_win_write) else $error("window write lost");

   property p_cs_reset;
      @(posedge mclk) rst |=> (wd_clock_source_sel == 3'h0);
   endproperty
   a_cs_reset: assert property (p_cs_reset) else $error("clock select reset wrong");

   property p_win_reset;
      @(posedge mclk) rst |=> (wd_window_sel == $past(config_window_sel));
   endproperty
   a_win_reset: assert property (p_win_reset) else $error("window reset wrong");

   sequence s_ctrl_read;
      avs_read && !ack_ff && (avs_address == CTRL_REG_OFFSET);
   endsequence
   property p_unused_zero;
      @(posedge mclk) disable iff (rst)
         s_ctrl_read |=> (avs_readdata[7] == 1'b0) && (avs_readdata[3] == 1'b0)
                         && !avs_waitrequest;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero");

   // Handshake: one wait state per request, none while idle
   sequence s_request_taken;
      (avs_read || avs_write) && !ack_ff;
   endsequence

   sequence s_cfg_read;
      avs_read && !ack_ff && (avs_address == CFG_STAT_OFFSET);
   endsequence

   sequence s_other_read;
      avs_read && !ack_ff && (avs_address != CTRL_REG_OFFSET)
      && (avs_address != CFG_STAT_OFFSET);
   endsequence

   sequence s_lane_off_write;
      avs_write && !ack_ff && !avs_byteenable[0];
   endsequence

   property p_wait_first;
      @(posedge mclk) disable iff (rst)
         s_request_taken |-> avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("new request not held off");

   property p_one_wait;
      @(posedge mclk) disable iff (rst)
         s_request_taken |=> !avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("request not answered");

   property p_idle_no_wait;
      @(posedge mclk) disable iff (rst)
         !(avs_read || avs_write) |-> !avs_waitrequest;
   endproperty
   a_idle_no_wait: assert property (p_idle_no_wait) else $error("wait while idle");

   property p_ack_single;
      @(posedge mclk) disable iff (rst)
         ack_ff |=> !ack_ff;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("acknowledge held too long");

   property p_rst_no_ack;
      @(posedge mclk) rst |=> !ack_ff;
   endproperty
   a_rst_no_ack: assert property (p_rst_no_ack) else $error("acknowledge after reset");

   // Selects move only on an accepted write
   property p_outputs_follow;
      @(posedge mclk) disable iff (rst)
         !(wr_ctrl && cs_wr_ok) |=> $stable(wd_clock_source_sel);
   endproperty
   a_outputs_follow: assert property (p_outputs_follow) else $error("clock select drift");

   property p_win_follow;
      @(posedge mclk) disable iff (rst)
         !(wr_ctrl && win_wr_ok) |=> $stable(wd_window_sel);
   endproperty
   a_win_follow: assert property (p_win_follow) else $error("window select drift");

   property p_lane_off;
      @(posedge mclk) disable iff (rst)
         s_lane_off_write |=> $stable(wd_clock_source_sel) && $stable(wd_window_sel);
   endproperty
   a_lane_off: assert property (p_lane_off) else $error("write without lane landed");

   // Read data views
   property p_ctrl_read_value;
      @(posedge mclk) disable iff (rst)
         s_ctrl_read |=> (avs_readdata[6:4] == $past(cs_ff))
                         && (avs_readdata[2:0] == $past(win_ff));
   endproperty
   a_ctrl_read_value: assert property (p_ctrl_read_value) else $error("control read wrong");

   property p_cfg_read;
      @(posedge mclk) disable iff (rst)
         s_cfg_read |=> (avs_readdata[6:4] == $past(config_clock_source_sel))
                        && (avs_readdata[2:0] == $past(config_window_sel));
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config status read wrong");

   property p_other_read;
      @(posedge mclk) disable iff (rst)
         s_other_read |=> (avs_readdata == UNMAPPED_READ);
   endproperty
   a_other_read: assert property (p_other_read) else $error("unmapped read not zero");

   property p_high_bytes_zero;
      @(posedge mclk) disable iff (rst)
         (avs_read && !ack_ff) |=> (avs_readdata[31:8] == 24'h00_0000);
   endproperty
   a_high_bytes_zero: assert property (p_high_bytes_zero) else $error("upper bytes not zero");

   property p_rdata_stands;
      @(posedge mclk) disable iff (rst)
         !(avs_read && !ack_ff) |=> $stable(avs_readdata);
   endproperty
   a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
endmodule
`default_nettype wire

// ### rtl/wcw_pkg.sv
// Package: register map, field layout and codes for the watchdog clock/window control
package wcw_pkg;
   localparam logic [3:0] ADDR_W              = 4'h4;
   localparam logic [3:0] CTRL_REG_OFFSET     = 4'h0;
   localparam logic [3:0] CFG_STAT_OFFSET     = 4'h4;
   localparam int         CS_LSB              = 4;
   localparam int         WIN_LSB             = 0;
   localparam logic [2:0] CFG_WRITABLE        = 3'h7;
   localparam logic [2:0] CS_RESET_CODE       = 3'h0;
   localparam logic [2:0] CS_LOW_FREQ_INTERNAL_OSC_CODE    = 3'h0;
   localparam logic [2:0] CS_MEDIUM_FREQ_INTERNAL_OSC_CODE    = 3'h1;
   localparam logic [2:0] WIN_FULL_OPEN       = 3'h7;
   localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;
   typedef enum logic [2:0] {
      WCW_LOW_FREQ_OSC = 3'h0,
      WCW_MED_FREQ_OSC = 3'h1
   } wcw_clk_src_t;
endpackage

// ### bench/tb_wcw_ctrl.sv
// Testbench for the watchdog clock and window select register
`timescale 1ns/100ps
`default_nettype none
module tb_wcw_ctrl;
   import wcw_pkg::*;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0]  be = 4'hf;
   logic [2:0]  cfg_c = 3'h7;
   logic [2:0]  cfg_w = 3'h5;
   logic [31:0] rdat;
   logic        wreq;
   logic [2:0]  cs;
   logic [2:0]  win;
   logic [31:0] got;
   int          errors = 0;
   int          n_compared = 0;
   always #2 mclk = ~mclk;
   wcw_ctrl u_dut (.mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wreq), .config_clock_source_sel(cfg_c),
      .config_window_sel(cfg_w), .wd_clock_source_sel(cs), .wd_window_sel(win));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Holds the request until waitrequest is sampled low, then releases
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int waits;
      waits = 0;
      @(posedge mclk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h00_0000, d};
      do begin
         @(posedge mclk);
         if (wreq !== 1'b0) begin
            waits++;
         end
      end while (wreq !== 1'b0);
      got = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      chk("wait states", 32'h1, waits);
   endtask
   task automatic reset_with(input logic [2:0] c, input logic [2:0] w);
      cfg_c <= c;
      cfg_w <= w;
      rst <= 1'b1;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   task automatic t_window_locked;
      reset_with(3'h7, 3'h5);
      chk("clock sel reset", 32'h0, cs);
      chk("window reset", 32'h5, win);
      bus(1'b1, CTRL_REG_OFFSET, 8'h9a);
      chk("clock sel write", 32'h1, cs);
      chk("window locked", 32'h5, win);
      bus(1'b0, CTRL_REG_OFFSET, 8'h00);
      chk("reg read", 32'h15, got);
      bus(1'b0, 4'h8, 8'h00);
      chk("unmapped read", UNMAPPED_READ, got);
   endtask
   task automatic t_status_lanes;
      reset_with(3'h7, 3'h7);
      chk("clock sel reset", 32'h0, cs);
      chk("window reset", 32'h7, win);
      chk("idle waitrequest", 32'h0, wreq);
      bus(1'b0, CFG_STAT_OFFSET, 8'h00);
      chk("config status read", 32'h77, got);
      be <= 4'he;
      bus(1'b1, CTRL_REG_OFFSET, 8'h13);
      chk("lane off clock sel", 32'h0, cs);
      chk("lane off window", 32'h7, win);
      be <= 4'hf;
      bus(1'b1, CTRL_REG_OFFSET, 8'h13);
      chk("clock sel write", 32'h1, cs);
      chk("window write", 32'h3, win);
      bus(1'b0, CTRL_REG_OFFSET, 8'h00);
      chk("reg read back", 32'h13, got);
   endtask
   task automatic t_clock_locked;
      reset_with(3'h2, 3'h7);
      chk("clock sel reset", 32'h0, cs);
      chk("window reset", 32'h7, win);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, CTRL_REG_OFFSET, {5'h13, i[2:0]});
         chk("window code", {29'h0, i[2:0]}, win);
         chk("clock locked", 32'h0, cs);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      complete_run();
   end
   initial begin
      t_window_locked();
      t_status_lanes();
      t_clock_locked();
      complete_run();
   end
endmodule
`default_nettype wire
